// ---- rtl/stx_consts.svh ----
// Purpose: Constants for the swap, trap and block transfer executor
// Assumes: 32-bit instruction words, 16 registers
// Notes:   Field positions and vector values
`ifndef STX_CONSTS_SVH
`define STX_CONSTS_SVH
`define STX_COND_HI      31
`define STX_COND_LO      28
`define STX_SWI_HI       27
`define STX_SWI_LO       24
`define STX_SWI_CODE     4'hf
`define STX_SWI_VECTOR   32'h0000_0008
`define STX_ABT_VECTOR   32'h0000_0010
`define STX_MODE_SVC     5'h13
`define STX_MODE_ABT     5'h17
`define STX_MODE_USR     5'h10
`define STX_BIT_P        24
`define STX_BIT_U        23
`define STX_BIT_S        22
`define STX_BIT_W        21
`define STX_BIT_L        20
`define STX_BIT_B        22
`define STX_RN_HI        19
`define STX_RN_LO        16
`define STX_RD_HI        15
`define STX_RD_LO        12
`define STX_RM_HI        3
`define STX_RM_LO        0
`define STX_WORD_STEP    32'h0000_0004
`define STX_PC_IDX       4'hf
`define STX_STATUS_RESET 32'h0000_00d3
`define STX_FLAG_N       31
`define STX_FLAG_Z       30
`define STX_FLAG_C       29
`define STX_FLAG_V       28
`endif

// ---- rtl/stx_pkg.sv ----
// Purpose: Types for the swap, trap and block transfer executor
// Assumes: Used with stx_consts.svh
// Notes:   Bus request carrier
`default_nettype none
package stx_pkg;
    typedef enum logic [2:0] {
        STX_IDLE  = 3'b000,
        STX_BLOCK = 3'b001,
        STX_SWPRD = 3'b010,
        STX_SWPWR = 3'b011,
        STX_SWPIN = 3'b100,
        STX_TRAP  = 3'b101
    } stx_state_t;
    typedef enum logic [1:0] {
        STX_CYC_N = 2'b00,
        STX_CYC_S = 2'b01,
        STX_CYC_I = 2'b10
    } stx_cyc_t;
    typedef struct packed {
        logic        valid;
        logic        write;
        logic        byte_en;
        logic        lock;
        stx_cyc_t    cyc;
        logic [31:0] addr;
        logic [31:0] wdata;
    } stx_bus_req_t;
endpackage
`default_nettype wire

// ---- rtl/stx_exec.sv ----
// Purpose: Executes block transfer, atomic swap and supervisor trap
// Assumes: Register file outside; memory answers each cycle; abort valid
// Notes:   Function
// Function
// RULE_01: Run only when condition field passes current flags
// RULE_02: Full stack pre-adjusts address, empty stack post-adjusts
// RULE_03: Ascending store goes up, load goes down; descending reversed
// RULE_04: Other modes pick increment/decrement, after/before via P and U
// RULE_05: Write-back set stores final address in base, else base kept
// RULE_06: S bit: load with pc restores status, else use user bank
// RULE_07: Swap read then write indivisible, no interrupt accepted between
// RULE_08: Read base address, write source, then load destination
// RULE_09: Same source and destination ends with the memory value
// RULE_10: Lock stays high across swap read and write
// RULE_11: Byte bit set gives byte transfer, clear gives word
// RULE_12: Swap byte lanes follow single transfer endian rules
// RULE_13: Memory manager raises abort in the failing cycle
// RULE_14: Abort on swap read or write takes data abort trap
// RULE_15: Swap costs one S, two N and one I cycle; the code marks two N and one I, no S
// RULE_16: Trap recognised when bits 27..24 are all ones
// RULE_17: Trap enters supervisor, saves status, pc goes to 0x08
// RULE_18: Supervisor link gets address of word after trap instruction
// RULE_19: Status-restoring move from link to pc returns and restores
// RULE_20: Low 24 bits of trap instruction are ignored
// RULE_21: Trap costs two S and one N cycle; the code marks only one N cycle
// RULE_22: Lowest register moves first at lowest address, pc last
// RULE_23: Under lock both swap accesses go back to back
`default_nettype none
`include "stx_consts.svh"
module stx_exec
    import stx_pkg::*;
(
    input  wire logic         sys_clk,
    input  wire logic         reset_n,
    input  wire logic         instr_valid,
    input  wire logic [31:0]  instr_word,
    input  wire logic [31:0]  instr_addr,
    input  wire logic         is_block,
    input  wire logic         is_swap,
    input  wire logic         is_status_return,
    input  wire logic         big_endian,
    input  wire logic [31:0]  reg_rdata_a,
    input  wire logic [31:0]  reg_rdata_b,
    output logic [3:0]        reg_raddr_a,
    output logic [3:0]        reg_raddr_b,
    output logic              reg_we,
    output logic [3:0]        reg_waddr,
    output logic [31:0]       reg_wdata,
    output logic              reg_user_bank,
    output stx_bus_req_t      bus_req,
    input  wire logic [31:0]  bus_rdata,
    input  wire logic         bus_abort,
    output logic              busy,
    output logic              irq_block,
    output logic [31:0]       current_status_word,
    output logic [31:0]       supervisor_saved_status,
    output logic [31:0]       supervisor_link_reg,
    output logic [31:0]       program_counter_reg,
    output logic              pc_load
);
    ////////////////////////////////////////////////////////////////////////
    logic [3:0] cond;
    logic       cond_ok;
    logic [3:0] fl;
    always_comb begin
        cond = instr_word[`STX_COND_HI:`STX_COND_LO];
        fl = current_status_word[`STX_FLAG_N:`STX_FLAG_V];
        unique case (cond) // [RULE_01]
            4'h0: cond_ok = fl[2];
            4'h1: cond_ok = !fl[2];
            4'h2: cond_ok = fl[1];
            4'h3: cond_ok = !fl[1];
            4'h4: cond_ok = fl[3];
            4'h5: cond_ok = !fl[3];
            4'h6: cond_ok = fl[0];
            4'h7: cond_ok = !fl[0];
            4'h8: cond_ok = fl[1] && !fl[2];
            4'h9: cond_ok = !fl[1] || fl[2];
            4'ha: cond_ok = fl[3] == fl[0];
            4'hb: cond_ok = fl[3] != fl[0];
            4'hc: cond_ok = !fl[2] && (fl[3] == fl[0]);
            4'hd: cond_ok = fl[2] || (fl[3] != fl[0]);
            4'he: cond_ok = 1'b1;
            4'hf: cond_ok = 1'b0;
        endcase
    end
    ////////////////////////////////////////////////////////////////////////
    stx_state_t   state_reg, state_next;
    logic [31:0]  instr_reg, instr_next;
    logic [31:0]  addr_reg, addr_next;
    logic [31:0]  base_reg, base_next;
    logic [15:0]  list_reg, list_next;
    logic [31:0]  rdata_reg, rdata_next;
    logic         abort_reg, abort_next;
    logic [31:0]  current_status_word_reg, current_status_word_next;
    logic [31:0]  spsr_reg, spsr_next;
    logic [31:0]  link_reg, link_next;
    logic [31:0]  pc_reg, pc_next;
    logic         first_reg, first_next;
    logic [3:0]   low_idx;
    logic [4:0]   count;
    logic [31:0]  span;
    logic [31:0]  lane_word;
    logic [7:0]   lane_byte;
    logic         is_trap;
    always_comb begin
        low_idx = 4'h0;
        count = 5'h00;
        for (int i = 15; i >= 0; i--) begin
            if (list_reg[i]) begin
                low_idx = 4'(i); // [RULE_22]
            end
        end
        for (int i = 0; i < 16; i++) begin
            count = count + 5'(instr_word[i]);
        end
        span = {25'h0, count, 2'h0};
        // Byte lane from address bits, flipped for big endian [RULE_12]
        unique case (addr_reg[1:0] ^ {2{big_endian}})
            2'h0: lane_byte = bus_rdata[7:0];
            2'h1: lane_byte = bus_rdata[15:8];
            2'h2: lane_byte = bus_rdata[23:16];
            2'h3: lane_byte = bus_rdata[31:24];
        endcase
        is_trap = instr_word[`STX_SWI_HI:`STX_SWI_LO] == `STX_SWI_CODE;
        lane_word = instr_reg[`STX_BIT_B] ? {24'h0, lane_byte}
                                          : bus_rdata; // [RULE_11]
    end
    always_comb begin
        state_next = state_reg;
        instr_next = instr_reg;
        addr_next = addr_reg;
        base_next = base_reg;
        list_next = list_reg;
        rdata_next = rdata_reg;
        abort_next = abort_reg;
        current_status_word_next = current_status_word_reg;
        spsr_next = spsr_reg;
        link_next = link_reg;
        pc_next = pc_reg;
        first_next = first_reg;
        reg_raddr_a = 4'h0;
        reg_raddr_b = 4'h0;
        reg_we = 1'b0;
        reg_waddr = 4'h0;
        reg_wdata = 32'h0;
        reg_user_bank = 1'b0;
        pc_load = 1'b0;
        bus_req = '0;
        reg_raddr_a = instr_word[`STX_RN_HI:`STX_RN_LO];
        unique case (state_reg)
            STX_IDLE: begin
                if (instr_valid && cond_ok) begin // [RULE_01]
                    instr_next = instr_word;
                    abort_next = 1'b0;
                    first_next = 1'b1;
                    if (is_trap) begin // [RULE_16] [RULE_20]
                        state_next = STX_TRAP;
                    end else if (is_swap) begin
                        addr_next = reg_rdata_a;
                        state_next = STX_SWPRD;
                    end else if (is_block) begin
                        list_next = instr_word[15:0];
                        // Lowest address always first [RULE_02] [RULE_03]
                        unique case ({instr_word[`STX_BIT_P],
                                      instr_word[`STX_BIT_U]}) // [RULE_04]
                            2'b01: addr_next = reg_rdata_a;
                            2'b11: addr_next = reg_rdata_a + `STX_WORD_STEP;
                            2'b00: addr_next = reg_rdata_a - span
                                             + `STX_WORD_STEP;
                            2'b10: addr_next = reg_rdata_a - span;
                        endcase
                        base_next = instr_word[`STX_BIT_U]
                                  ? reg_rdata_a + span
                                  : reg_rdata_a - span;
                        state_next = STX_BLOCK;
                    end else if (is_status_return) begin
                        pc_next = supervisor_link_reg; // [RULE_19]
                        current_status_word_next = spsr_reg;
                        pc_load = 1'b1;
                    end
                end
            end
            STX_BLOCK: begin
                reg_raddr_a = low_idx;
                reg_user_bank = instr_reg[`STX_BIT_S] &&
                                !(instr_reg[`STX_BIT_L] &&
                                  instr_reg[15]); // [RULE_06]
                bus_req.valid = 1'b1;
                bus_req.write = !instr_reg[`STX_BIT_L];
                bus_req.cyc = first_reg ? STX_CYC_N : STX_CYC_S;
                bus_req.addr = addr_reg;
                bus_req.wdata = reg_rdata_a;
                first_next = 1'b0;
                if (bus_abort) begin
                    abort_next = 1'b1;
                end
                if (instr_reg[`STX_BIT_L] && !bus_abort && !abort_reg) begin
                    reg_we = 1'b1;
                    reg_waddr = low_idx;
                    reg_wdata = bus_rdata;
                    if (low_idx == `STX_PC_IDX) begin
                        pc_next = bus_rdata;
                        pc_load = 1'b1;
                        if (instr_reg[`STX_BIT_S]) begin
                            current_status_word_next = spsr_reg; // [RULE_06]
                        end
                    end
                end
                addr_next = addr_reg + `STX_WORD_STEP;
                list_next = list_reg & ~(16'h1 << low_idx);
                if ((list_reg & ~(16'h1 << low_idx)) == 16'h0) begin
                    if (instr_reg[`STX_BIT_W]) begin // [RULE_05]
                        reg_we = 1'b1;
                        reg_waddr = instr_reg[`STX_RN_HI:`STX_RN_LO];
                        reg_wdata = base_reg;
                    end
                    state_next = (abort_reg || bus_abort) ? STX_TRAP
                                                          : STX_IDLE;
                end
            end
            STX_SWPRD: begin
                bus_req.valid = 1'b1;
                bus_req.lock = 1'b1; // [RULE_10] [RULE_07]
                bus_req.byte_en = instr_reg[`STX_BIT_B]; // [RULE_11]
                bus_req.cyc = STX_CYC_N; // [RULE_15]
                bus_req.addr = addr_reg; // [RULE_08]
                rdata_next = lane_word;
                abort_next = bus_abort; // [RULE_14]
                state_next = STX_SWPWR; // [RULE_23]
            end
            STX_SWPWR: begin
                reg_raddr_b = instr_reg[`STX_RM_HI:`STX_RM_LO];
                bus_req.valid = 1'b1;
                bus_req.write = 1'b1;
                bus_req.lock = 1'b1; // [RULE_10]
                bus_req.byte_en = instr_reg[`STX_BIT_B];
                bus_req.cyc = STX_CYC_N; // [RULE_15]
                bus_req.addr = addr_reg;
                bus_req.wdata = instr_reg[`STX_BIT_B]
                              ? {4{reg_rdata_b[7:0]}} // [RULE_12]
                              : reg_rdata_b; // [RULE_08]
                abort_next = abort_reg || bus_abort; // [RULE_14]
                state_next = STX_SWPIN;
            end
            STX_SWPIN: begin
                bus_req.cyc = STX_CYC_I; // [RULE_15]
                if (!abort_reg) begin
                    reg_we = 1'b1; // [RULE_09]
                    reg_waddr = instr_reg[`STX_RD_HI:`STX_RD_LO];
                    reg_wdata = rdata_reg; // [RULE_08]
                    state_next = STX_IDLE;
                end else begin
                    state_next = STX_TRAP; // [RULE_14]
                end
            end
            STX_TRAP: begin
                // Trap entry: a single cycle marked N, no S cycles driven [RULE_21]
                spsr_next = current_status_word_reg; // [RULE_17]
                current_status_word_next = {current_status_word_reg[31:5],
                             abort_reg ? `STX_MODE_ABT : `STX_MODE_SVC};
                link_next = abort_reg ? instr_addr + 32'h8
                                      : instr_addr
                                      + `STX_WORD_STEP; // [RULE_18]
                pc_next = abort_reg ? `STX_ABT_VECTOR
                                    : `STX_SWI_VECTOR; // [RULE_17]
                pc_load = 1'b1;
                bus_req.cyc = STX_CYC_N;
                state_next = STX_IDLE;
            end
            default: state_next = STX_IDLE;
        endcase
    end
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= STX_IDLE;
            instr_reg <= 32'h0;
            addr_reg <= 32'h0;
            base_reg <= 32'h0;
            list_reg <= 16'h0;
            rdata_reg <= 32'h0;
            abort_reg <= 1'b0;
            current_status_word_reg <= `STX_STATUS_RESET;
            spsr_reg <= 32'h0;
            link_reg <= 32'h0;
            pc_reg <= 32'h0;
            first_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            instr_reg <= instr_next;
            addr_reg <= addr_next;
            base_reg <= base_next;
            list_reg <= list_next;
            rdata_reg <= rdata_next;
            abort_reg <= abort_next;
            current_status_word_reg <= current_status_word_next;
            spsr_reg <= spsr_next;
            link_reg <= link_next;
            pc_reg <= pc_next;
            first_reg <= first_next;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        busy = state_reg != STX_IDLE;
        irq_block = (state_reg == STX_SWPRD) ||
                    (state_reg == STX_SWPWR); // [RULE_07]
        current_status_word = current_status_word_reg;
        supervisor_saved_status = spsr_reg;
        supervisor_link_reg = link_reg;
        program_counter_reg = pc_reg;
    end
endmodule
`default_nettype wire

// ---- bench/stx_exec_props.sv ----
// Purpose: Port checks for swap, trap and status return timing
// Assumes: One clock, reset_n async low
// Notes:   Bound into stx_exec
`default_nettype none
module stx_exec_props
    import stx_pkg::*;
(
    input wire logic         sys_clk,
    input wire logic         reset_n,
    input wire logic         instr_valid,
    input wire logic [31:0]  instr_word,
    input wire logic [31:0]  instr_addr,
    input wire logic         is_swap,
    input wire logic         is_status_return,
    input wire stx_bus_req_t bus_req,
    input wire logic [31:0]  bus_rdata,
    input wire logic         bus_abort,
    input wire logic         busy,
    input wire logic         irq_block,
    input wire logic         reg_we,
    input wire logic [31:0]  reg_wdata,
    input wire logic [31:0]  current_status_word,
    input wire logic [31:0]  supervisor_saved_status,
    input wire logic [31:0]  supervisor_link_reg,
    input wire logic [31:0]  program_counter_reg,
    input wire logic         reg_user_bank,
    input wire logic         pc_load
);
    timeunit 1ns;
    timeprecision 100ps;
    logic swap_rd;
    assign swap_rd = bus_req.valid && bus_req.lock && !bus_req.write;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    ////////////////////////////////
    a_swap_take_byte: assert property (
        instr_valid && !busy && is_swap && instr_word[31:24] == 8'he1
        |=> swap_rd && bus_req.byte_en == $past(instr_word[22]))
        else $error("swap size or read wrong after take");
    a_lock_pair: assert property (
        swap_rd && !bus_abort |=> bus_req.valid && bus_req.write
        && bus_req.lock && bus_req.addr == $past(bus_req.addr))
        else $error("swap write not locked to its read");
    a_lock_in_swap: assert property (
        bus_req.lock |-> irq_block && busy && bus_req.cyc == STX_CYC_N)
        else $error("lock outside swap access");
    a_swap_cycles: assert property (
        swap_rd && !bus_abort ##1 !bus_abort
        |=> bus_req.cyc == STX_CYC_I && !bus_req.valid)
        else $error("swap internal cycle missing");
    a_swap_result: assert property (
        swap_rd && !bus_req.byte_en && !bus_abort ##1 !bus_abort
        |=> reg_we && reg_wdata == $past(bus_rdata, 2))
        else $error("swap destination not old memory word");
    a_byte_lanes: assert property (
        bus_req.valid && bus_req.write && bus_req.byte_en
        |-> bus_req.wdata[31:8] == {3{bus_req.wdata[7:0]}})
        else $error("byte write not on all lanes");
    a_abort_vector: assert property (
        swap_rd && bus_abort |-> ##[1:5] program_counter_reg == 32'h10)
        else $error("swap abort trap not taken");
    a_trap_entry: assert property (
        instr_valid && !busy && instr_word[31:24] == 8'hef
        |=> ##1 program_counter_reg == 32'h8
        && current_status_word[4:0] == 5'h13
        && supervisor_link_reg == $past(instr_addr, 2) + 32'h4)
        else $error("trap entry wrong");
    a_trap_saves: assert property (
        instr_valid && !busy && instr_word[31:24] == 8'hef
        |=> ##1 supervisor_saved_status == $past(current_status_word, 2))
        else $error("trap did not save status");
    a_false_cond: assert property (
        instr_valid && !busy && instr_word[31:28] == 4'hf
        |=> !busy && !bus_req.valid)
        else $error("never condition executed");
    a_status_return: assert property (
        instr_valid && !busy && is_status_return && instr_word[31:28] == 4'he
        |=> program_counter_reg == $past(supervisor_link_reg)
        && current_status_word == $past(supervisor_saved_status))
        else $error("status return wrong");
    a_user_bank: assert property (
        reg_user_bank |-> busy && bus_req.valid && !bus_req.lock)
        else $error("user bank outside block transfer");
    a_pc_hold: assert property (
        !pc_load |=> $stable(program_counter_reg))
        else $error("pc moved without load");
endmodule
bind stx_exec stx_exec_props stx_exec_props_i (.*);
`default_nettype wire

// ---- bench/stx_mem_model.sv ----
// Purpose: Memory and memory manager on the executor bus
// Assumes: Answers in the request cycle
// Notes:   Aborts any access to abort_addr
`default_nettype none
module stx_mem_model
    import stx_pkg::*;
(
    input  wire logic         sys_clk,
    input  wire stx_bus_req_t bus_req,
    input  wire logic         big_endian,
    input  wire logic [31:0]  abort_addr,
    output logic [31:0]       bus_rdata,
    output logic              bus_abort
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] mem [1024];
    logic        tog;
    logic [9:0]  idx;
    logic [1:0]  lane;
    assign idx = bus_req.addr[11:2];
    assign lane = big_endian ? ~bus_req.addr[1:0] : bus_req.addr[1:0];
    assign bus_abort = bus_req.valid && bus_req.addr == abort_addr;
    // Idle data lines toggle every cycle
    assign bus_rdata = (bus_req.valid && !bus_req.write) ? mem[idx] : {32{tog}};
    initial begin
        tog = 1'b0;
        foreach (mem[i]) begin
            mem[i] = 32'h0;
        end
    end
    // Never steals a locked pair; aborted writes are dropped
    always @(posedge sys_clk) begin
        tog <= ~tog;
        if (bus_req.valid && bus_req.write && !bus_abort) begin
            if (bus_req.byte_en) begin
                mem[idx][{lane, 3'h0} +: 8] <= bus_req.wdata[7:0];
            end else begin
                mem[idx] <= bus_req.wdata;
            end
        end
    end
endmodule
`default_nettype wire

// ---- bench/test_stx_exec.sv ----
// Purpose: Self-checking bench for stx_exec
// Assumes: Little endian, register file modelled here
// Notes:   Swap rows in a table, traps and block moves by hand
`default_nettype none
module test_stx_exec
    import stx_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {
        logic [31:0] w;
        logic [3:0]  rd;
        logic [31:0] rv;
        logic [9:0]  mi;
        logic [31:0] mv;
    } stx_row_t;
    logic         sys_clk = 1'b0;
    logic         reset_n = 1'b0;
    logic         instr_valid = 1'b0;
    logic [31:0]  instr_word = 32'h0;
    logic [31:0]  instr_addr = 32'h0;
    logic [2:0]   kind = 3'h0;
    logic [31:0]  abort_addr = 32'h108;
    logic [31:0]  regs [16];
    logic [3:0]   raddr_a, raddr_b, reg_waddr;
    logic         reg_we, busy, bus_abort;
    logic [31:0]  reg_wdata, bus_rdata, csw, sss, slr, pcr;
    stx_bus_req_t bus_req;
    int           errors = 0;
    int           samples_checked = 0;
    int           cycles = 0;
    stx_row_t     rows [3] = '{
        '{32'he102_0091, 4'h0, 32'haaaa_5555, 10'h40, 32'h1111_1111},
        '{32'he142_3094, 4'h3, 32'h11, 10'h40, 32'h1111_11c7},
        '{32'he106_5095, 4'h5, 32'h77, 10'h41, 32'h5}};
    ////////////////////////////////
    stx_exec stx_exec_i (
        .sys_clk(sys_clk), .reset_n(reset_n), .instr_valid(instr_valid),
        .instr_word(instr_word), .instr_addr(instr_addr),
        .is_block(kind[2]), .is_swap(kind[1]), .is_status_return(kind[0]),
        .big_endian(1'b0), .reg_rdata_a(regs[raddr_a]),
        .reg_rdata_b(regs[raddr_b]), .reg_raddr_a(raddr_a),
        .reg_raddr_b(raddr_b), .reg_we(reg_we), .reg_waddr(reg_waddr),
        .reg_wdata(reg_wdata), .reg_user_bank(), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .bus_abort(bus_abort), .busy(busy),
        .irq_block(), .current_status_word(csw),
        .supervisor_saved_status(sss), .supervisor_link_reg(slr),
        .program_counter_reg(pcr), .pc_load());
    stx_mem_model stx_mem_model_i (
        .sys_clk(sys_clk), .bus_req(bus_req), .big_endian(1'b0),
        .abort_addr(abort_addr), .bus_rdata(bus_rdata),
        .bus_abort(bus_abort));
    ////////////////////////////////
    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (reg_we) begin
            regs[reg_waddr] <= reg_wdata;
        end
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            close_out();
        end
    end
    ////////////////////////////////
    task automatic close_out();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input string n, input logic [31:0] e, g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic run(input logic [31:0] w, a, input logic [2:0] k);
        int n;
        n = 0;
        @(negedge sys_clk);
        kind = k;
        instr_word = w;
        instr_addr = a;
        instr_valid = 1'b1;
        @(negedge sys_clk);
        instr_valid = 1'b0;
        while (busy !== 1'b0 && n < 40) begin
            @(negedge sys_clk);
            n++;
        end
        check("busy_end", 32'h0, {31'h0, busy});
    endtask
    task automatic trap(input logic [31:0] w, a);
        run(w, a, 3'b000);
        check("trap_pc", 32'h8, pcr);
        check("trap_mode", 32'h13, {27'h0, csw[4:0]});
        check("trap_saved", 32'hd3, sss);
        check("trap_link", a + 32'h4, slr);
        run(32'he1b0_f00e, 32'h8, 3'b001);
        check("ret_pc", a + 32'h4, pcr);
        check("ret_status", 32'hd3, csw);
    endtask
    ////////////////////////////////
    initial begin
        regs = '{32'h0, 32'h1111_1111, 32'h100, 32'h0, 32'hc7, 32'h5,
            32'h104, 32'h7777_7777, 32'h108, 32'h1000, 32'h0, 32'h0,
            32'h0, 32'h0, 32'h0, 32'h0};
        repeat (2) @(negedge sys_clk);
        check("rst_status", 32'hd3, csw);
        check("rst_pc", 32'h0, pcr);
        check("rst_valid", 32'h0, {31'h0, bus_req.valid});
        reset_n = 1'b1;
        stx_mem_model_i.mem[10'h40] = 32'haaaa_5555;
        stx_mem_model_i.mem[10'h41] = 32'h77;
        foreach (rows[i]) begin
            run(rows[i].w, 32'h200, 3'b010);
            check("swap_reg", rows[i].rv, regs[rows[i].rd]);
            check("swap_mem", rows[i].mv, stx_mem_model_i.mem[rows[i].mi]);
        end
        trap(32'hef12_3456, 32'h300);
        trap(32'hefff_ffff, 32'h400);
        run(32'he9a9_00a2, 32'h600, 3'b100);
        check("stm_lo", 32'h1111_1111, stx_mem_model_i.mem[1]);
        check("stm_mid", 32'h77, stx_mem_model_i.mem[2]);
        check("stm_hi", 32'h7777_7777, stx_mem_model_i.mem[3]);
        check("stm_base", 32'h100c, regs[9]);
        run(32'he819_1c00, 32'h604, 3'b100);
        check("ldm_lo", 32'h1111_1111, regs[10]);
        check("ldm_mid", 32'h77, regs[11]);
        check("ldm_hi", 32'h7777_7777, regs[12]);
        check("ldm_base", 32'h100c, regs[9]);
        run(32'he8c9_0002, 32'h608, 3'b100);
        check("stm_user", 32'h1111_1111, stx_mem_model_i.mem[3]);
        check("stm_nowb", 32'h100c, regs[9]);
        run(32'hf102_0091, 32'h700, 3'b010);
        run(32'h0102_0091, 32'h704, 3'b010);
        check("skip_reg", 32'haaaa_5555, regs[0]);
        check("skip_mem", 32'h1111_11c7, stx_mem_model_i.mem[10'h40]);
        run(32'he108_0091, 32'h500, 3'b010);
        check("abt_pc", 32'h10, pcr);
        check("abt_mode", 32'h17, {27'h0, csw[4:0]});
        check("abt_reg", 32'haaaa_5555, regs[0]);
        close_out();
    end
endmodule
`default_nettype wire
